// file: rtl/spswc_ctrl.v
// System power-state controller with wake-source gating
`default_nettype none
`include "spswc_defs.vh"
module spswc_ctrl #(
  parameter DEB_CYC = `SPSWC_DEB_CYC,
  parameter HOLD_CYC = `SPSWC_HOLD_CYC
) (
  input wire clk,
  input wire nrst,
  input wire pwrBtn,
  input wire [7:0] wakeEvt,
  input wire s5LanWakeEn,
  input wire s5PmeWakeEn,
  input wire swReqValid,
  input wire [2:0] swReq,
  input wire lastStateOn,
  input wire restorePolicyEn,
  input wire restoreForceOn,
  output reg [2:0] sysState,
  output reg mainPowerOn,
  output reg cpuStopGrant,
  output reg contextKept,
  output reg wakeLogicPowered,
  output reg wakeTaken
);
  wire shortPress;
  wire longPress;
  reg [2:0] next_state;
  reg [2:0] powerTarget;
  reg restored;
  reg wakeOk;

  spswc_button #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) uButton (
    .clk(clk),
    .nrst(nrst),
    .btnRaw(pwrBtn),
    .shortPress(shortPress),
    .longPress(longPress)
  );

  // Wake gating by source class and current sleep state
  function wakeAllowed;
    input [2:0] st;
    input [7:0] ev;
    input lanEn;
    input pmeEn;
    reg deep;
    reg shallow;
    begin
      shallow = (st == `SPSWC_S1) || (st == `SPSWC_S3);
      deep = (st == `SPSWC_S4) || (st == `SPSWC_S5);
      wakeAllowed = 1'b0;
      if (shallow || deep) begin
        if (ev[`SPSWC_W_PWR] || ev[`SPSWC_W_RTC] || ev[`SPSWC_W_PCIE]) begin
          wakeAllowed = 1'b1;
        end
        if (ev[`SPSWC_W_LAN] && (st != `SPSWC_S5 || lanEn)) begin
          wakeAllowed = 1'b1;
        end
        if (ev[`SPSWC_W_PME] && (st != `SPSWC_S5 || pmeEn)) begin
          wakeAllowed = 1'b1;
        end
      end
      if (shallow && (ev[`SPSWC_W_MODEM] || ev[`SPSWC_W_PS2] || ev[`SPSWC_W_USB])) begin
        wakeAllowed = 1'b1;
      end
    end
  endfunction

  // State to take after power returns: policy override, else last state
  function [2:0] restoreState;
    input polEn;
    input forceOn;
    input lastOn;
    begin
      if (polEn) begin
        restoreState = forceOn ? `SPSWC_S0 : `SPSWC_S5;
      end else begin
        restoreState = lastOn ? `SPSWC_S0 : `SPSWC_S5;
      end
    end
  endfunction

  // Next state: long press beats short, switch beats software, wake last
  always @* begin
    next_state = sysState;
    wakeOk = wakeAllowed(sysState, wakeEvt, s5LanWakeEn, s5PmeWakeEn);
    if (longPress) begin
      if (sysState != `SPSWC_S5) begin
        next_state = `SPSWC_S5;
      end
    end else if (shortPress) begin
      case (sysState)
        `SPSWC_S0: next_state = `SPSWC_S1;
        `SPSWC_S1: next_state = `SPSWC_S0;
        `SPSWC_S3: next_state = `SPSWC_S0;
        `SPSWC_S4: next_state = `SPSWC_S0;
        `SPSWC_S5: next_state = `SPSWC_S0;
        default: next_state = `SPSWC_S5;
      endcase
    end else if (swReqValid && sysState == `SPSWC_S0) begin
      case (swReq)
        `SPSWC_REQ_S1: next_state = `SPSWC_S1;
        `SPSWC_REQ_S3: next_state = `SPSWC_S3;
        `SPSWC_REQ_S4: next_state = `SPSWC_S4;
        `SPSWC_REQ_S5: next_state = `SPSWC_S5;
        default: next_state = sysState;
      endcase
    end else if (wakeOk) begin
      next_state = `SPSWC_S0;
    end
  end

  // State register; the first cycle after reset loads the policy state, else the prior state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sysState <= `SPSWC_S5;
      restored <= 1'b0;
      wakeTaken <= 1'b0;
    end else if (!restored) begin
      // Strap-like inputs read after release, never inside reset
      restored <= 1'b1;
      wakeTaken <= 1'b0;
      sysState <= restoreState(restorePolicyEn, restoreForceOn, lastStateOn);
    end else begin
      sysState <= next_state;
      wakeTaken <= wakeOk && !longPress && !shortPress &&
                   !(swReqValid && sysState == `SPSWC_S0);
    end
  end

  // State the register takes at this edge, so power rails track it exactly
  always @* begin
    powerTarget = next_state;
    if (!restored) begin
      powerTarget = restoreState(restorePolicyEn, restoreForceOn, lastStateOn);
    end
  end

  // Power outputs decoded from state, registered to stay glitch free
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mainPowerOn <= 1'b0;
      cpuStopGrant <= 1'b0;
      contextKept <= 1'b0;
      wakeLogicPowered <= 1'b1;
    end else begin
      mainPowerOn <= (powerTarget == `SPSWC_S0) || (powerTarget == `SPSWC_S1);
      cpuStopGrant <= (powerTarget == `SPSWC_S1);
      contextKept <= (powerTarget == `SPSWC_S1) || (powerTarget == `SPSWC_S0);
      wakeLogicPowered <= 1'b1;
    end
  end
endmodule // spswc_ctrl
`default_nettype wire

// file: rtl/spswc_defs.vh
// Constants for the system power-state and wake controller
`ifndef SPSWC_DEFS_VH
`define SPSWC_DEFS_VH
// System state encodings
`define SPSWC_S0 3'h0
`define SPSWC_S1 3'h1
`define SPSWC_S3 3'h3
`define SPSWC_S4 3'h4
`define SPSWC_S5 3'h5
// Software request codes
`define SPSWC_REQ_S1 3'h1
`define SPSWC_REQ_S3 3'h3
`define SPSWC_REQ_S4 3'h4
`define SPSWC_REQ_S5 3'h5
// Timing: clock rate, debounce time and long-press threshold
`define SPSWC_CLK_HZ 10000000
`define SPSWC_DEB_US 10000
`define SPSWC_DEB_CYC ((`SPSWC_DEB_US * (`SPSWC_CLK_HZ / 1000000)))
`define SPSWC_HOLD_S 4
`define SPSWC_HOLD_CYC (`SPSWC_HOLD_S * `SPSWC_CLK_HZ)
// Wake source bit positions
`define SPSWC_W_LAN 0
`define SPSWC_W_PME 1
`define SPSWC_W_PWR 2
`define SPSWC_W_RTC 3
`define SPSWC_W_PCIE 4
`define SPSWC_W_MODEM 5
`define SPSWC_W_PS2 6
`define SPSWC_W_USB 7
`endif

// file: rtl/spswc_button.v
// Power switch debounce and press-duration timer
`default_nettype none
module spswc_button #(
  parameter DEB_CYC = 100000,
  parameter HOLD_CYC = 40000000
) (
  input wire clk,
  input wire nrst,
  input wire btnRaw,
  output reg shortPress,
  output reg longPress
);
  reg [16:0] debCount;
  reg btnClean;
  reg [25:0] holdCount;
  reg longDone;

  // Debounce: the clean level follows only after a stable run
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      debCount <= 17'h00000;
      btnClean <= 1'b0;
    end else if (btnRaw == btnClean) begin
      debCount <= 17'h00000;
    end else if (debCount >= DEB_CYC[16:0] - 17'h00001) begin
      debCount <= 17'h00000;
      btnClean <= btnRaw;
    end else begin
      debCount <= debCount + 17'h00001;
    end
  end

  // Held time; long fires at threshold, short fires on early release
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdCount <= 26'h0000000;
      longDone <= 1'b0;
      shortPress <= 1'b0;
      longPress <= 1'b0;
    end else begin
      shortPress <= 1'b0;
      longPress <= 1'b0;
      if (btnClean) begin
        if (!longDone) begin
          if (holdCount >= HOLD_CYC[25:0] - 26'h0000001) begin
            longPress <= 1'b1;
            longDone <= 1'b1;
          end else begin
            holdCount <= holdCount + 26'h0000001;
          end
        end
      end else begin
        // A long press has already acted, so its release is silent
        if (holdCount != 26'h0000000 && !longDone) begin
          shortPress <= 1'b1;
        end
        holdCount <= 26'h0000000;
        longDone <= 1'b0;
      end
    end
  end
endmodule // spswc_button
`default_nettype wire

// file: test/spswc_switch.sv
// Front-panel power switch model: holds the switch for a set number of cycles
`default_nettype none
module spswc_switch (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  output logic pwrBtn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  // Press length counted on the standby clock, switch closed while counting
  always @(posedge clk) left <= go ? len : left - {7'h00, left != 8'h00};
  assign pwrBtn = left != 8'h00;
endmodule // spswc_switch
`default_nettype wire

// file: test/spswc_ctrl_props.sv
// Port assertions for the power-state and wake controller
`default_nettype none
module spswc_ctrl_props #(
  parameter int DEB_CYC = 4,
  parameter int HOLD_CYC = 50
) (
  input wire clk,
  input wire nrst,
  input wire pwrBtn,
  input wire [7:0] wakeEvt,
  input wire s5LanWakeEn,
  input wire s5PmeWakeEn,
  input wire swReqValid,
  input wire [2:0] swReq,
  input wire [2:0] sysState,
  input wire mainPowerOn,
  input wire cpuStopGrant,
  input wire wakeLogicPowered,
  input wire wakeTaken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  int hi;
  // Raw press length; margin covers debounce plus the decision edge
  always @(posedge clk or negedge nrst)
    if (!nrst) hi <= 0;
    else hi <= pwrBtn ? hi + 1 : 0;
  a_stop_grant: assert property ($past(nrst) |-> cpuStopGrant == (sysState == 3'h1))
    else $error("stop-grant wrong");
  a_main_power: assert property ($past(nrst) |-> mainPowerOn == (sysState <= 3'h1))
    else $error("main power wrong");
  a_wake_powered: assert property (wakeLogicPowered)
    else $error("wake logic unpowered");
  a_sw_request: assert property (sysState == 3'h0 && swReqValid && !pwrBtn
    && swReq >= 3'h3 && swReq <= 3'h5 |=> sysState == $past(swReq)) else $error("sw ignored");
  a_wake_pulse: assert property (wakeTaken |-> sysState == 3'h0 && $past(sysState) != 3'h0)
    else $error("stray wake");
  a_deep_ignore: assert property (sysState >= 3'h4 && wakeEvt[4:0] == 5'h00 && !pwrBtn
    |=> !wakeTaken) else $error("deep wake");
  a_lan_off: assert property (sysState == 3'h5 && !s5LanWakeEn && !s5PmeWakeEn
    && wakeEvt[7:2] == 6'h00 && !pwrBtn |=> !wakeTaken) else $error("s5 lan wake");
  a_long_off: assert property (hi == DEB_CYC + HOLD_CYC + 6 |-> sysState == 3'h5)
    else $error("long press");
  a_usb_s1: assert property (sysState == 3'h1 && wakeEvt == 8'h80 && !pwrBtn
    && !swReqValid |=> sysState == 3'h0 && wakeTaken) else $error("usb wake");
  c_wake: cover property (wakeTaken);
  c_sleep: cover property (sysState == 3'h1);
  c_off: cover property (hi == DEB_CYC + HOLD_CYC + 6);
endmodule // spswc_ctrl_props
bind spswc_ctrl spswc_ctrl_props #(.DEB_CYC(DEB_CYC), .HOLD_CYC(HOLD_CYC)) u_props (
  .clk(clk), .nrst(nrst), .pwrBtn(pwrBtn), .wakeEvt(wakeEvt), .s5LanWakeEn(s5LanWakeEn),
  .s5PmeWakeEn(s5PmeWakeEn), .swReqValid(swReqValid), .swReq(swReq), .sysState(sysState),
  .mainPowerOn(mainPowerOn), .cpuStopGrant(cpuStopGrant),
  .wakeLogicPowered(wakeLogicPowered), .wakeTaken(wakeTaken));
`default_nettype wire

// file: test/spswc_ctrl_tb.sv
// Self-checking bench for the power-state and wake controller
`default_nettype none
module spswc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 4;
  logic clk = 0, nrst = 0, go = 0, swReqValid = 0, lanEn = 0, pmeEn = 0, polEn = 0;
  logic lastOn = 0;
  logic [7:0] len = 0, wakeEvt = 0;
  logic [2:0] swReq = 0;
  wire pwrBtn, mainOn, stopGnt, ctxKept, wakePwr, wakeTaken;
  wire [2:0] sysState;
  int mismatches = 0, checks = 0, cyc = 0;
  spswc_switch u_spswc_switch (.clk(clk), .go(go), .len(len), .pwrBtn(pwrBtn));
  spswc_ctrl #(.DEB_CYC(DEB), .HOLD_CYC(50)) u_spswc_ctrl (.clk(clk), .nrst(nrst),
    .pwrBtn(pwrBtn), .wakeEvt(wakeEvt), .s5LanWakeEn(lanEn), .s5PmeWakeEn(pmeEn),
    .swReqValid(swReqValid), .swReq(swReq), .lastStateOn(lastOn), .restorePolicyEn(polEn),
    .restoreForceOn(polEn), .sysState(sysState), .mainPowerOn(mainOn),
    .cpuStopGrant(stopGnt), .contextKept(ctxKept), .wakeLogicPowered(wakePwr),
    .wakeTaken(wakeTaken));
  initial forever #50 clk = ~clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard sized well above the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [2:0] exp);
    checks++;
    if (sysState !== exp || mainOn !== (exp <= 3'h1) || ctxKept !== (exp <= 3'h1)
        || stopGnt !== (exp == 3'h1)) begin
      mismatches++;
      $display("CHECK FAILED %0t state %0h not %0h power %b%b%b", $time, sysState, exp,
               mainOn, ctxKept, stopGnt);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic press(input logic [7:0] n, input logic [2:0] exp);
    @(posedge clk) {go, len} <= {1'b1, n};
    @(posedge clk) go <= 0;
    step(n + 2 * DEB + 6);
    #1 chk(exp);
  endtask
  task automatic sw(input logic [2:0] code);
    @(posedge clk) {swReqValid, swReq} <= {1'b1, code};
    @(posedge clk) swReqValid <= 0;
    step(1);
    #1 chk(code);
  endtask
  task automatic wake(input logic [7:0] ev, input logic [2:0] exp);
    @(posedge clk) wakeEvt <= ev;
    step(2);
    wakeEvt <= 0;
    step(2);
    #1 chk(exp);
  endtask
  // Single-bit wake event outcome by sleep state and S5 enables
  function automatic logic [2:0] nxt(input logic [2:0] st, input logic [7:0] ev);
    logic ok;
    ok = |ev[4:2] || (|ev[7:5] && st <= 3'h3)
      || (|ev[1:0] && (st != 3'h5 || (lanEn && ev[0]) || (pmeEn && ev[1])));
    return ok ? 3'h0 : st;
  endfunction
  initial begin
    logic [7:0] ev;
    logic [2:0] code;
    void'($urandom(32'hE8B45B78));
    step(6);
    nrst <= 1;
    step(2);
    #1 chk(3'h5);
    press(8'h0A, 3'h0);
    press(8'h0A, 3'h1);
    wake(8'h80, 3'h0);
    for (int i = 0; i < 15; i++) begin
      ev = 8'h01 << ($urandom % 8);
      code = 3'h3 + 3'(i % 3);
      {lanEn, pmeEn} <= 2'(i / 3);
      sw(code);
      wake(ev, nxt(code, ev));
      if (sysState !== 3'h0) wake(8'h08, 3'h0);
    end
    sw(3'h4);
    press(8'h0A, 3'h0);
    sw(3'h3);
    press(8'h46, 3'h5);
    press(8'h0A, 3'h0);
    press(8'h46, 3'h5);
    press(8'h0A, 3'h0);
    @(posedge clk) {nrst, polEn} <= 2'b01;
    step(2);
    nrst <= 1;
    step(2);
    #1 chk(3'h0);
    @(posedge clk) {nrst, polEn, lastOn} <= 3'b001;
    step(2);
    nrst <= 1;
    step(2);
    #1 chk(3'h0);
    end_of_test();
  end
endmodule // spswc_ctrl_tb
`default_nettype wire
